// [hw/mode_register_write_path.sv]
// Mode-register write path: init sequence, user MRW requests, APB status.
// Assumes one pclk domain; bank_idle comes from the precharge tracker.
//
// Function
// - Any of 256 mode registers may be targeted.
// - Register number and opcode go out on the command/address bus.
// - The memory data bus never carries mode register traffic.
// - An MRW on the local command input starts register programming.
// - After programming, internal settings follow the new register value.
// - Register number is local address bits 7:0.
// - Programming value is local address bits 15:8.
// - Initialization programs mode registers with configured initial values.
// - Registers never rewritten keep their initialization settings.
// - Default MR1: burst code 011, write recovery code 100.
// - Default MR2: latency code 0100, read six, write three.
// - Default MR3: drive strength code 0010, 40 ohm.
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module mode_register_write_path (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic [3:0]              cmd_in,
    input  wire logic                    cmd_valid,
    input  wire logic [mrw_pkg::ADDR_WIDTH-1:0] local_addr,
    output logic                         cmd_ready,
    input  wire logic                    mem_busy,
    input  wire logic                    bank_idle,
    output logic [9:0]                   mem_cmd_addr_bus_out,
    output logic                         mem_cs_n,
    output logic                         mem_dq_oe,
    output logic                         init_done,
    output logic [2:0]                   burst_len_code,
    output logic [3:0]                   read_lat,
    output logic [3:0]                   write_lat,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr
);
    // ----------------------------------------
    // Types and state
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_INIT1 = 3'b000,
        ST_INIT2 = 3'b001,
        ST_INIT3 = 3'b010,
        ST_IDLE  = 3'b011,
        ST_WAIT  = 3'b100,
        ST_SEND  = 3'b101
    } seq_state_type;

    typedef struct packed {
        seq_state_type st;
        logic [7:0]    num;
        logic [7:0]    val;
        logic          init_done;
        logic          reinit;
        logic [15:0]   count;
        logic [31:0]   rdata;
    } top_state_type;

    top_state_type s_q;
    top_state_type s_d;

    mrw_cmd_if cmd ();

    logic       enc_take;
    logic       is_mrw;
    logic       apb_acc;
    logic       apb_wr;
    logic [3:0] ds_unused;
    logic [2:0] wr_rec;
    logic [3:0] drv;

    // Data pins stay undriven for the whole of every mode register access
    assign mem_dq_oe = 1'b0;

    assign is_mrw   = cmd_valid && (cmd_in == mrw_pkg::CMD_MRW);
    assign enc_take = cmd.valid && cmd.ready;
    assign apb_acc  = psel && penable;
    assign apb_wr   = apb_acc && pwrite;
    assign ds_unused = drv;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        s_d       = s_q;
        cmd.valid = 1'b0;
        cmd.num   = s_q.num;
        cmd.val   = s_q.val;
        cmd_ready = 1'b0;
        case (s_q.st)
            ST_INIT1: begin
                cmd.valid = 1'b1;
                cmd.num   = mrw_pkg::MR1_NUM;
                cmd.val   = mrw_pkg::MR1_INIT;
                if (cmd.ready) begin
                    s_d.st = ST_INIT2;
                end
            end
            ST_INIT2: begin
                cmd.valid = 1'b1;
                cmd.num   = mrw_pkg::MR2_NUM;
                cmd.val   = mrw_pkg::MR2_INIT;
                if (cmd.ready) begin
                    s_d.st = ST_INIT3;
                end
            end
            ST_INIT3: begin
                cmd.valid = 1'b1;
                cmd.num   = mrw_pkg::MR3_NUM;
                cmd.val   = mrw_pkg::MR3_INIT;
                if (cmd.ready) begin
                    s_d.st        = ST_IDLE;
                    s_d.init_done = 1'b1;
                end
            end
            ST_IDLE: begin
                // Refuse while a rerun of init is pending, else the request is lost
                cmd_ready = !s_q.reinit;
                if (s_q.reinit) begin
                    s_d.reinit    = 1'b0;
                    s_d.init_done = 1'b0;
                    s_d.st        = ST_INIT1;
                end else if (is_mrw) begin
                    // Number and value are sampled from one request
                    s_d.num = local_addr[mrw_pkg::MR_NUM_MSB:mrw_pkg::MR_NUM_LSB];
                    s_d.val = local_addr[mrw_pkg::MR_VAL_MSB:mrw_pkg::MR_VAL_LSB];
                    s_d.st  = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Holding here costs latency but avoids clashing with open rows
                if (!mem_busy && bank_idle && !cmd.busy) begin
                    s_d.st = ST_SEND;
                end
            end
            ST_SEND: begin
                cmd.valid = 1'b1;
                if (cmd.ready) begin
                    s_d.count = s_q.count + 16'h0001;
                    s_d.st    = ST_IDLE;
                end
            end
            default: s_d.st = ST_INIT1;
        endcase

        // ----------------------------------------
        // APB slave, zero wait states
        // ----------------------------------------
        if (apb_wr && (paddr == mrw_pkg::REG_CTRL) && pwdata[mrw_pkg::CTRL_INIT_BIT]) begin
            s_d.reinit = 1'b1;
        end
        if (psel && !penable && !pwrite) begin
            case (paddr)
                mrw_pkg::REG_CTRL:   s_d.rdata = {31'h0, s_q.reinit};
                mrw_pkg::REG_STATUS: s_d.rdata = {13'h0000, s_q.st, 7'h00,
                                                  cmd.busy, 7'h00, s_q.init_done};
                mrw_pkg::REG_SHADOW: s_d.rdata = {12'h000, ds_unused, read_lat,
                                                  write_lat, 1'b0, wr_rec,
                                                  1'b0, burst_len_code};
                mrw_pkg::REG_COUNT:  s_d.rdata = {16'h0000, s_q.count};
                default:             s_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{st: ST_INIT1, num: 8'h00, val: 8'h00, init_done: 1'b0,
                     reinit: 1'b0, count: 16'h0000, rdata: 32'h00000000};
        end else begin
            s_q <= s_d;
        end
    end

    assign init_done = s_q.init_done;
    assign prdata    = s_q.rdata;
    assign pready    = 1'b1;
    assign pslverr   = apb_acc && (paddr != mrw_pkg::REG_CTRL) && (paddr != mrw_pkg::REG_STATUS)
                       && (paddr != mrw_pkg::REG_SHADOW) && (paddr != mrw_pkg::REG_COUNT);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    mrw_ca_encoder u_enc (
        .pclk                 (pclk),
        .presetn              (presetn),
        .cmd                  (cmd.dst),
        .mem_cmd_addr_bus_out (mem_cmd_addr_bus_out),
        .mem_cs_n             (mem_cs_n)
    );

    // Shadow follows every accepted write, init ones included
    mrw_shadow u_shadow (
        .pclk           (pclk),
        .presetn        (presetn),
        .wr_stb         (enc_take),
        .wr_num         (cmd.num),
        .wr_val         (cmd.val),
        .burst_len_code (burst_len_code),
        .wr_recovery    (wr_rec),
        .read_lat       (read_lat),
        .write_lat      (write_lat),
        .drive_strength (drv)
    );
endmodule : mode_register_write_path
`default_nettype wire

// [hw/mrw_ca_encoder.sv]
// Turns one mode-register write into two command/address bus words.
// Assumes the source holds valid until ready.
`timescale 1ns/10ps
`default_nettype none
module mrw_ca_encoder (
    input  wire logic  pclk,
    input  wire logic  presetn,
    mrw_cmd_if.dst     cmd,
    output logic [9:0] mem_cmd_addr_bus_out,
    output logic       mem_cs_n
);
    typedef struct packed {
        logic [1:0] phase;
        logic [7:0] num;
        logic [7:0] val;
        logic [9:0] ca;
        logic       cs_n;
    } enc_state_type;

    enc_state_type s_q;
    enc_state_type s_d;

    assign cmd.ready = (s_q.phase == mrw_pkg::CA_IDLE);
    assign cmd.busy  = (s_q.phase != mrw_pkg::CA_IDLE);

    // ----------------------------------------
    // Two-word sequence
    // ----------------------------------------
    always_comb begin
        s_d      = s_q;
        s_d.ca   = mrw_pkg::CA_NOP_WORD;
        s_d.cs_n = 1'b1;
        case (s_q.phase)
            mrw_pkg::CA_IDLE: begin
                if (cmd.valid) begin
                    s_d.num   = cmd.num;
                    s_d.val   = cmd.val;
                    s_d.phase = mrw_pkg::CA_MRW_A;
                end
            end
            mrw_pkg::CA_MRW_A: begin
                // Register number rides the CA bus, never the data bus
                s_d.ca    = {s_q.num[5:0], mrw_pkg::CA_MRW_OPC};
                s_d.cs_n  = 1'b0;
                s_d.phase = mrw_pkg::CA_MRW_B;
            end
            mrw_pkg::CA_MRW_B: begin
                s_d.ca    = {s_q.val, s_q.num[7:6]};
                s_d.phase = mrw_pkg::CA_IDLE;
            end
            default: s_d.phase = mrw_pkg::CA_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{phase: mrw_pkg::CA_IDLE, num: 8'h00, val: 8'h00,
                     ca: mrw_pkg::CA_NOP_WORD, cs_n: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign mem_cmd_addr_bus_out = s_q.ca;
    assign mem_cs_n             = s_q.cs_n;
endmodule : mrw_ca_encoder
`default_nettype wire

// [hw/mrw_cmd_if.sv]
// Carries one mode-register write from the sequencer to the bus encoder.
// Assumes both ends share pclk.
`timescale 1ns/10ps
`default_nettype none
interface mrw_cmd_if;
    logic       valid;
    logic       ready;
    logic [7:0] num;
    logic [7:0] val;
    logic       busy;

    modport src (output valid, output num, output val, input ready, input busy);
    modport dst (input valid, input num, input val, output ready, output busy);
endinterface : mrw_cmd_if
`default_nettype wire

// [hw/mrw_pkg.sv]
// Constants shared by the mode-register write path and its helpers.
// Assumes a single 40 MHz pclk domain and an APB register port.
package mrw_pkg;

    // ----------------------------------------
    // Command codes on the local command input
    // ----------------------------------------
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_MRW = 4'hA;

    // ----------------------------------------
    // Local address field layout
    // ----------------------------------------
    localparam int MR_NUM_LSB = 0;
    localparam int MR_NUM_MSB = 7;
    localparam int MR_VAL_LSB = 8;
    localparam int MR_VAL_MSB = 15;
    localparam int ADDR_WIDTH = 28;

    // ----------------------------------------
    // Command/address bus encodings
    // ----------------------------------------
    localparam logic [1:0] CA_IDLE  = 2'h0;
    localparam logic [1:0] CA_MRW_A = 2'h1;
    localparam logic [1:0] CA_MRW_B = 2'h2;
    localparam logic [9:0] CA_NOP_WORD = 10'h007;
    localparam logic [3:0] CA_MRW_OPC  = 4'h0;

    // ----------------------------------------
    // Mode register numbers and init defaults
    // ----------------------------------------
    localparam logic [7:0] MR1_NUM = 8'h01;
    localparam logic [7:0] MR2_NUM = 8'h02;
    localparam logic [7:0] MR3_NUM = 8'h03;
    localparam logic [2:0] MR1_BL_DEF  = 3'b011;
    localparam logic [2:0] MR1_WR_DEF  = 3'b100;
    localparam logic [3:0] MR2_LAT_DEF = 4'b0100;
    localparam logic [3:0] MR3_DS_DEF  = 4'b0010;
    localparam int BL_LSB  = 0;
    localparam int WR_LSB  = 5;
    localparam int LAT_LSB = 0;
    localparam int DS_LSB  = 0;
    localparam logic [7:0] MR1_INIT = {MR1_WR_DEF, 2'b00, MR1_BL_DEF};
    localparam logic [7:0] MR2_INIT = {4'h0, MR2_LAT_DEF};
    localparam logic [7:0] MR3_INIT = {4'h0, MR3_DS_DEF};

    // ----------------------------------------
    // APB register offsets
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SHADOW = 8'h08;
    localparam logic [7:0] REG_COUNT  = 8'h0C;
    localparam int CTRL_INIT_BIT = 0;

endpackage : mrw_pkg

// [hw/mrw_shadow.sv]
// Controller-side copy of the settings held in mode registers 1 to 3.
// Assumes writes arrive as single-cycle strobes.
`timescale 1ns/10ps
`default_nettype none
module mrw_shadow (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       wr_stb,
    input  wire logic [7:0] wr_num,
    input  wire logic [7:0] wr_val,
    output logic [2:0]      burst_len_code,
    output logic [2:0]      wr_recovery,
    output logic [3:0]      read_lat,
    output logic [3:0]      write_lat,
    output logic [3:0]      drive_strength
);
    typedef struct packed {
        logic [7:0] mr1;
        logic [7:0] mr2;
        logic [7:0] mr3;
    } shadow_state_type;

    shadow_state_type s_q;
    shadow_state_type s_d;

    // Untouched registers keep their init copy
    always_comb begin
        s_d = s_q;
        if (wr_stb) begin
            case (wr_num)
                mrw_pkg::MR1_NUM: s_d.mr1 = wr_val;
                mrw_pkg::MR2_NUM: s_d.mr2 = wr_val;
                mrw_pkg::MR3_NUM: s_d.mr3 = wr_val;
                default: s_d = s_q;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{mr1: mrw_pkg::MR1_INIT, mr2: mrw_pkg::MR2_INIT,
                     mr3: mrw_pkg::MR3_INIT};
        end else begin
            s_q <= s_d;
        end
    end

    // Latency code maps to read/write latency pairs (code 4 gives 6/3)
    always_comb begin
        read_lat  = s_q.mr2[mrw_pkg::LAT_LSB +: 4] + 4'h2;
        write_lat = s_q.mr2[mrw_pkg::LAT_LSB +: 4] - 4'h1;
    end

    assign burst_len_code = s_q.mr1[mrw_pkg::BL_LSB +: 3];
    assign wr_recovery    = s_q.mr1[mrw_pkg::WR_LSB +: 3];
    assign drive_strength = s_q.mr3[mrw_pkg::DS_LSB +: 4];
endmodule : mrw_shadow
`default_nettype wire

// [sim/mode_register_write_path_tb.sv]
// Self-checking bench for the mode-register write path.
// Assumes the checker and user model files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module mode_register_write_path_tb;
    typedef struct packed {
        logic [7:0] num;
        logic [7:0] val;
        logic [2:0] bl;
        logic [3:0] rl;
        logic [3:0] wl;
    } row_type;
    localparam row_type ROWS [6] = '{'{8'h05, 8'hA5, 3'h3, 4'h6, 4'h3},
        '{8'h01, 8'h82, 3'h2, 4'h6, 4'h3}, '{8'h02, 8'h06, 3'h2, 4'h8, 4'h5},
        '{8'h00, 8'h5A, 3'h2, 4'h8, 4'h5}, '{8'hFF, 8'hC3, 3'h2, 4'h8, 4'h5},
        '{8'h40, 8'h11, 3'h2, 4'h8, 4'h5}};
    logic pclk, presetn, cmd_valid, cmd_ready, mem_busy, bank_idle, mem_cs_n, mem_dq_oe;
    logic init_done, psel, penable, pwrite, pready, pslverr;
    logic [3:0]  cmd_in, read_lat, write_lat;
    logic [2:0]  burst_len_code;
    logic [27:0] local_addr;
    logic [9:0]  mem_cmd_addr_bus_out;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        err;
    int num_errors = 0;
    int samples_checked = 0;
    mode_register_write_path i_mode_register_write_path (.*);
    mrw_user_model i_mrw_user_model (.pclk(pclk), .cmd_ready(cmd_ready), .cmd_in(cmd_in),
        .cmd_valid(cmd_valid), .local_addr(local_addr));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ----------------
    // Tasks
    // ----------------
    task automatic end_of_test();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_level(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 300) begin
            @(negedge pclk);
            n++;
        end
        if (n == 300) begin
            num_errors++;
            end_of_test();
        end
    endtask : wait_level
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50) wait_level(pready, 1'b1);
    endtask : apb
    task automatic reset_and_defaults();
        presetn <= 1'b0;
        @(negedge pclk);
        check({mem_cmd_addr_bus_out, mem_cs_n, init_done, cmd_ready, mem_dq_oe}, 14'h0078);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        wait_level(init_done, 1'b1);
        check({burst_len_code, read_lat, write_lat}, 11'h363);
        apb(1'b0, mrw_pkg::REG_SHADOW, 32'h0);
        check(rd, 32'h00026343);
    endtask : reset_and_defaults
    // ----------------
    // Sequence
    // ----------------
    initial begin
        {presetn, mem_busy, psel, penable, pwrite, paddr, pwdata} = '0;
        bank_idle = 1'b1;
        reset_and_defaults();
        foreach (ROWS[i]) begin
            i_mrw_user_model.send(mrw_pkg::CMD_MRW, ROWS[i].num, ROWS[i].val, 0, 300);
            wait_level(mem_cs_n, 1'b0);
            check(mem_cmd_addr_bus_out, {ROWS[i].num[5:0], 4'h0});
            @(negedge pclk);
            check(mem_cmd_addr_bus_out, {ROWS[i].val, ROWS[i].num[7:6]});
            @(negedge pclk);
            check({burst_len_code, read_lat, write_lat}, ROWS[i][10:0]);
        end
        i_mrw_user_model.send(4'h3, 8'h01, 8'h07, 2, 8);
        @(negedge pclk);
        check({mem_cs_n, burst_len_code}, 4'hA);
        @(posedge pclk);
        mem_busy <= 1'b1;
        i_mrw_user_model.send(mrw_pkg::CMD_MRW, 8'h01, 8'h84, 3, 300);
        repeat (20) @(negedge pclk) check(mem_cs_n, 1'b1);
        @(posedge pclk);
        {mem_busy, bank_idle} <= 2'b00;
        repeat (10) @(negedge pclk) check(mem_cs_n, 1'b1);
        @(posedge pclk);
        bank_idle <= 1'b1;
        wait_level(mem_cs_n, 1'b0);
        repeat (2) @(negedge pclk);
        check(burst_len_code, 3'h4);
        apb(1'b0, mrw_pkg::REG_COUNT, 32'h0);
        check({i_mrw_user_model.misses[15:0], rd[15:0]}, 32'h00000007);
        apb(1'b0, 8'h40, 32'h0);
        check(rd, 32'h00000000);
        check({30'h0, err, pready}, 32'h00000003);
        apb(1'b1, mrw_pkg::REG_CTRL, 32'h1);
        repeat (40) @(negedge pclk);
        check({burst_len_code, read_lat, write_lat}, 11'h363);
        @(posedge pclk);
        reset_and_defaults();
        end_of_test();
    end
endmodule : mode_register_write_path_tb
bind mode_register_write_path mrw_asserts i_mrw_asserts (.pclk(pclk), .presetn(presetn),
    .cmd_in(cmd_in), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .mem_busy(mem_busy),
    .bank_idle(bank_idle), .mem_cmd_addr_bus_out(mem_cmd_addr_bus_out),
    .mem_cs_n(mem_cs_n), .mem_dq_oe(mem_dq_oe), .init_done(init_done),
    .burst_len_code(burst_len_code), .read_lat(read_lat), .write_lat(write_lat));
`default_nettype wire

// [sim/mrw_asserts.sv]
// Port assertions for the mode-register write path.
// Assumes a bind from the bench top file; one pclk domain.
`timescale 1ns/10ps
`default_nettype none
module mrw_asserts (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic [3:0] cmd_in,
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic       mem_busy,
    input wire logic       bank_idle,
    input wire logic [9:0] mem_cmd_addr_bus_out,
    input wire logic       mem_cs_n,
    input wire logic       mem_dq_oe,
    input wire logic       init_done,
    input wire logic [2:0] burst_len_code,
    input wire logic [3:0] read_lat,
    input wire logic [3:0] write_lat
);
    // ----------------
    // Sequences
    // ----------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence take_s;
        cmd_valid && cmd_ready && cmd_in == mrw_pkg::CMD_MRW;
    endsequence
    sequence pair_s;
        mem_cs_n ##1 mem_cmd_addr_bus_out == mrw_pkg::CA_NOP_WORD;
    endsequence
    sequence mr1_s;
        !mem_cs_n && mem_cmd_addr_bus_out[9:4] == 6'h01 ##1 mem_cmd_addr_bus_out[1:0] == 2'h0;
    endsequence
    // ----------------
    // Assertions
    // ----------------
    a_dq_bus_quiet: assert property (mem_dq_oe == 1'b0)
        else $error("data bus enabled");
    a_take_drops_ready: assert property (take_s |=> !cmd_ready)
        else $error("ready after take");
    a_take_then_issue: assert property (take_s |-> ##[3:300] !mem_cs_n)
        else $error("no command word");
    a_word_pair_nop: assert property (!mem_cs_n |=> pair_s)
        else $error("bad word pair");
    a_idle_is_nop: assert property (mem_cs_n && $past(mem_cs_n) |->
        mem_cmd_addr_bus_out == mrw_pkg::CA_NOP_WORD) else $error("idle word");
    // Three cycles; the wait-to-send pipeline spans four samples, ST_WAIT decision included
    a_busy_holds_off: assert property ((mem_busy || !bank_idle)[*3] |-> mem_cs_n)
        else $error("issued while busy");
    a_init_defaults: assert property ($rose(init_done) |-> burst_len_code == 3'h3
        && read_lat == 4'h6 && write_lat == 4'h3) else $error("init defaults");
    a_shadow_follows: assert property (mr1_s |->
        burst_len_code == mem_cmd_addr_bus_out[4:2]) else $error("shadow stale");
endmodule : mrw_asserts
`default_nettype wire

// [sim/mrw_user_model.sv]
// User logic on the local command input.
// Assumes calls from the bench; holds each request until it is taken or lim cycles pass.
`timescale 1ns/10ps
`default_nettype none
module mrw_user_model (
    input  wire logic        pclk,
    input  wire logic        cmd_ready,
    output logic [3:0]       cmd_in,
    output logic             cmd_valid,
    output logic [27:0]      local_addr
);
    int misses = 0;
    initial begin
        cmd_in = mrw_pkg::CMD_NOP;
        cmd_valid = 1'b0;
        local_addr = 28'h0000000;
    end
    // Lim bounds the wait; a refused MRW gives up after it and adds one to misses
    task automatic send(input logic [3:0] c, input logic [7:0] num, input logic [7:0] val,
                        input int lag, input int lim);
        int n;
        n = 0;
        // Requests always start just after a rising edge
        repeat (lag + 1) @(posedge pclk);
        cmd_in <= c;
        cmd_valid <= 1'b1;
        local_addr <= {12'hFFF, val, num};
        do begin
            @(posedge pclk);
            n++;
        end while ((cmd_ready !== 1'b1 || c != mrw_pkg::CMD_MRW) && n < lim);
        if (n == lim && c == mrw_pkg::CMD_MRW) misses++;
        cmd_in <= mrw_pkg::CMD_NOP;
        cmd_valid <= 1'b0;
        // Released lines show no stale copy of the request
        local_addr <= ~local_addr;
    endtask : send
endmodule : mrw_user_model
`default_nettype wire
